// ---- core/osd_pkg.sv ----
// package: register map, field positions, encodings and timing for the oscillator controller
package osd_pkg;
  // avalon word addresses (byte address / 4)
  localparam logic [1:0] ADDR_OSC_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_CLOCK_DIVISOR = 2'h1;
  localparam logic [1:0] ADDR_PLL_FEEDBACK = 2'h2;
  localparam logic [1:0] ADDR_FAST_RC_TUNING = 2'h3;
  // oscillator_control fields
  localparam int CUR_LSB = 12;
  localparam int REQ_LSB = 8;
  localparam int CLK_LOCK_BIT = 7;
  localparam int PIN_LOCK_BIT = 6;
  localparam int PLL_LOCK_BIT = 5;
  localparam int CLK_FAIL_BIT = 3;
  localparam int SEC_EN_BIT = 1;
  localparam int SWITCH_BIT = 0;
  // clock_divisor fields
  localparam int RECOVER_BIT = 15;
  localparam int REDUCE_LSB = 12;
  localparam int REDUCE_EN_BIT = 11;
  localparam int FRC_POST_LSB = 8;
  localparam int PLL_POST_LSB = 6;
  localparam int PLL_PRE_LSB = 0;
  // writable masks, unimplemented bits drop writes and read zero
  localparam logic [15:0] CLOCK_DIVISOR_MASK = 16'hffdf;
  localparam logic [15:0] PLL_FEEDBACK_MASK = 16'h01ff;
  localparam logic [15:0] FAST_RC_TUNING_MASK = 16'h003f;
  // reset values
  localparam logic [15:0] CLOCK_DIVISOR_RST = 16'h3040;
  localparam logic [15:0] PLL_FEEDBACK_RST = 16'h0030;
  localparam logic [15:0] FAST_RC_TUNING_RST = 16'h0000;
  // source encoding
  typedef enum logic [2:0] {
    OSD_SRC_FRC = 3'h0,
    OSD_SRC_FRC_PLL = 3'h1,
    OSD_SRC_PRI = 3'h2,
    OSD_SRC_PRI_PLL = 3'h3,
    OSD_SRC_SEC = 3'h4,
    OSD_SRC_LOW_POWER_INTERNAL_RC = 3'h5,
    OSD_SRC_FRC_DIV16 = 3'h6,
    OSD_SRC_FRC_DIVN = 3'h7
  } osd_src_t;
  // primary submode encoding
  localparam logic [1:0] PRI_EXT_CLOCK = 2'h0;
  localparam logic [1:0] PRI_STD_XTAL = 2'h1;
  localparam logic [1:0] PRI_HS_XTAL = 2'h2;
  // switch-enable / monitor configuration value that allows the lock bit
  localparam logic [1:0] MONITOR_CFG_SWITCH_ONLY = 2'h1;
  // settle cycles of the new clock before the switch
  localparam logic [3:0] SETTLE_CYCLES = 4'ha;
  localparam logic [1:0] PLL_POST_RESERVED = 2'h2;
  localparam logic [2:0] FRC_POST_256 = 3'h7;
  localparam logic [2:0] REDUCE_ONE = 3'h0;
endpackage : osd_pkg

// ---- core/osd_clock_ctrl.sv ----
// oscillator select, switch sequencer and clock divisor register file
//
// What this block does
// - start-up source comes from 3-bit config field, eight documented encodings.
// - primary submode field picks HS 10, XT 01, EC 00; ignored otherwise.
// - erased config gives fast RC divide-by-N start-up, code 111.
// - current source is read-only in control bits 14-12.
// - requested source writable in bits 10-8, loaded from config at reset.
// - with config 0b01, lock bit 7 set blocks clock switching.
// - bit 6 set rejects pin-remap register writes.
// - bit 5 reads 1 when PLL locked or start-up timer expired; here only when a PLL source is current and locked, outside start-up.
// - clock-fail bit set by monitor, cleared by software, resets 0.
// - control bit 1 enables the secondary oscillator.
// - software sets bit 0 to request a switch; hardware clears when done.
// - recover bit set means interrupts clear reduce-enable, ratio 1:1.
// - reduction field divides by two to the code, reset 011.
// - reduce-enable bit 11 applies ratio; clear forces 1:1.
// - fast RC postscaler divides by 2^code, code 111 by 256.
// - PLL post-divider 00 /2, 01 /4 default, 11 /8, 10 reserved.
// - PLL pre-divider divides by code plus two, 2 to 33.
// - PLL multiplier is code plus two, reset 50.
// - trim field is two's complement, 0.375 percent steps.
// - switching never changes primary submode; only config does.
// - switching enabled only when switch-enable config bit is 0.
// - with switching disabled requested field ignored, request bit held 0.
// - request to the current source aborts and clears request bit.
// - valid switch clears lock and fail, waits start-up, lock, 10 new cycles.
// - after switch, requested source copies to current, request clears.
// - on failure raise trap and move to fast RC, keeping PLL use.
`timescale 1ns/1ps
module osd_clock_ctrl (
  // clock, reset, enable
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // avalon-mm slave
  input wire logic [1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // nonvolatile configuration
  input wire logic [2:0] i_initial_source_cfg,
  input wire logic [1:0] i_primary_submode_cfg,
  input wire logic [1:0] i_switch_monitor_cfg,
  // oscillator side status
  input wire logic i_osc_ready,
  input wire logic i_pll_locked,
  input wire logic i_new_clk_tick,
  input wire logic i_clock_fail,
  input wire logic i_interrupt,
  // clock steering outputs
  output osd_pkg::osd_src_t o_active_source,
  output logic [1:0] o_primary_submode,
  output logic o_pll_in_use,
  output logic o_secondary_osc_enable,
  output logic o_start_source,
  output osd_pkg::osd_src_t o_start_target,
  output logic o_mux_select_pulse,
  output logic o_pin_remap_lock,
  output logic o_clock_fail_trap,
  output logic [2:0] o_reduce_ratio,
  output logic [2:0] o_fast_rc_postscale,
  output logic [1:0] o_pll_post_divider,
  output logic [4:0] o_pll_pre_divider,
  output logic [8:0] o_pll_multiplier,
  output logic [5:0] o_fast_rc_trim
);
  import osd_pkg::*;

  // idle, wait for start-up and lock, count settle ticks, then hand over in one cycle
  typedef enum logic [1:0] {
    OSD_IDLE,
    OSD_START,
    OSD_SETTLE,
    OSD_DONE
  } osd_state_t;

  // a source uses the pll in exactly two encodings
  function automatic logic uses_pll(input osd_src_t s);
    uses_pll = (s == OSD_SRC_FRC_PLL) || (s == OSD_SRC_PRI_PLL);
  endfunction : uses_pll

  // merge a 16-bit write through byte enables and a writable mask
  // only the low half of the bus word exists; upper byte enables are ignored
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                           input logic [3:0] be, input logic [15:0] mask);
    logic [15:0] v;
    v = old;
    if (be[0]) begin
      v[7:0] = wd[7:0];
    end
    if (be[1]) begin
      v[15:8] = wd[15:8];
    end
    merge16 = v & mask;
  endfunction : merge16

  // registers
  // settle_cnt counts new-clock ticks only while settling
  osd_state_t state;
  osd_src_t current_source;
  osd_src_t requested_source;
  logic clock_source_lock;
  logic pin_remap_lock;
  logic pll_lock_flag;
  logic clock_fail_flag;
  logic secondary_osc_enable;
  logic switch_request;
  logic [15:0] clock_divisor;
  logic [15:0] pll_feedback_divisor;
  logic [15:0] fast_rc_tuning;
  logic [3:0] settle_cnt;
  logic boot_done;
  logic ack_pending;

  // decoded conditions shared by several processes
  logic switch_enabled;
  logic switch_locked;
  logic bus_write;
  logic bus_read;
  logic [15:0] control_view;
  logic [15:0] next_divisor;

  // erased cfg bit 1 means switching and monitor off; lock bit only matters at 0b01
  assign switch_enabled = ~i_switch_monitor_cfg[1];
  assign switch_locked = clock_source_lock && (i_switch_monitor_cfg == MONITOR_CFG_SWITCH_ONLY);
  // a write or read acts on the second edge of its request, when the acknowledge shows
  assign bus_write = i_ce && i_avs_write && ack_pending;
  assign bus_read = i_ce && i_avs_read && ack_pending;

  // control register read image, unimplemented bits are zero
  always_comb begin
    control_view = '0;
    control_view[CUR_LSB +: 3] = current_source;
    control_view[REQ_LSB +: 3] = requested_source;
    control_view[CLK_LOCK_BIT] = clock_source_lock;
    control_view[PIN_LOCK_BIT] = pin_remap_lock;
    control_view[PLL_LOCK_BIT] = pll_lock_flag;
    control_view[CLK_FAIL_BIT] = clock_fail_flag;
    control_view[SEC_EN_BIT] = secondary_osc_enable;
    control_view[SWITCH_BIT] = switch_request;
  end

  // one wait state: waitrequest drops the cycle after a request arrives
  // a master that drops its request early loses the access; the strobe must be held
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ack_pending <= 1'b0;
      o_avs_waitrequest <= 1'b1;
    end else if (i_ce) begin
      ack_pending <= (i_avs_read || i_avs_write) && !ack_pending;
      o_avs_waitrequest <= !((i_avs_read || i_avs_write) && !ack_pending);
    end
  end

  // read data, registered so it stands at the acknowledging edge
  // the value is caught when the request is taken and holds until the next read
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_avs_readdata <= '0;
    end else if (i_ce && (i_avs_read && !ack_pending)) begin
      unique case (i_avs_address)
        ADDR_OSC_CONTROL: o_avs_readdata <= {16'h0000, control_view};
        ADDR_CLOCK_DIVISOR: o_avs_readdata <= {16'h0000, clock_divisor};
        ADDR_PLL_FEEDBACK: o_avs_readdata <= {16'h0000, pll_feedback_divisor};
        ADDR_FAST_RC_TUNING: o_avs_readdata <= {16'h0000, fast_rc_tuning};
      endcase
    end
  end

  // start-up source caught by a clocked process after reset release
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      boot_done <= 1'b0;
    end else if (i_ce) begin
      boot_done <= 1'b1;
    end
  end

  // switch sequencer and current source
  // a failure overrides a switch in progress; the request stays set and is retried
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state <= OSD_IDLE;
      current_source <= OSD_SRC_FRC_DIVN; // erased default
      settle_cnt <= '0;
    end else if (i_ce) begin
      if (!boot_done || !switch_enabled) begin
        current_source <= osd_src_t'(i_initial_source_cfg);
        state <= OSD_IDLE;
      end else if (i_clock_fail && current_source != OSD_SRC_FRC
                   && current_source != OSD_SRC_FRC_PLL) begin
        // fail-over keeps pll multiplication if it was in use
        current_source <= uses_pll(current_source) ? OSD_SRC_FRC_PLL : OSD_SRC_FRC;
        state <= OSD_IDLE;
      end else begin
        unique case (state)
          // a locked source leaves the request pending until the lock bit clears
          OSD_IDLE: begin
            if (switch_request && !switch_locked) begin
              state <= (requested_source == current_source) ? OSD_IDLE : OSD_START;
            end
          end
          OSD_START: begin
            // wait for start-up timer and, for pll targets, lock
            if (i_osc_ready && (!uses_pll(requested_source) || i_pll_locked)) begin
              state <= OSD_SETTLE;
              settle_cnt <= '0;
            end
          end
          OSD_SETTLE: begin
            if (i_new_clk_tick) begin
              settle_cnt <= settle_cnt + 4'h1;
              if (settle_cnt == SETTLE_CYCLES - 4'h1) begin
                state <= OSD_DONE;
              end
            end
          end
          // hand over; the mux pulse leaves the output stage one cycle later
          OSD_DONE: begin
            current_source <= requested_source;
            state <= OSD_IDLE;
          end
        endcase
      end
    end
  end

  // oscillator_control writable bits and switch request
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      requested_source <= OSD_SRC_FRC_DIVN;
      clock_source_lock <= 1'b0;
      pin_remap_lock <= 1'b0;
      secondary_osc_enable <= 1'b0;
      switch_request <= 1'b0;
    end else if (i_ce) begin
      // the first running edge after reset copies the configured start-up source
      if (!boot_done) begin
        requested_source <= osd_src_t'(i_initial_source_cfg);
      end else if (bus_write && i_avs_address == ADDR_OSC_CONTROL) begin
        if (i_avs_byteenable[1]) begin
          requested_source <= osd_src_t'(i_avs_writedata[REQ_LSB +: 3]);
        end
        if (i_avs_byteenable[0]) begin
          clock_source_lock <= i_avs_writedata[CLK_LOCK_BIT];
          pin_remap_lock <= i_avs_writedata[PIN_LOCK_BIT];
          secondary_osc_enable <= i_avs_writedata[SEC_EN_BIT];
        end
      end
      // completion and abort clear the request; a write of 1 sets it
      if (!switch_enabled) begin
        switch_request <= 1'b0;
      end else if (bus_write && i_avs_address == ADDR_OSC_CONTROL && i_avs_byteenable[0]
                   && i_avs_writedata[SWITCH_BIT]) begin
        switch_request <= 1'b1;
      end else if (state == OSD_DONE) begin
        switch_request <= 1'b0;
      end else if (state == OSD_IDLE && switch_request && !switch_locked
                   && requested_source == current_source) begin
        switch_request <= 1'b0;
      end
    end
  end

  // pll lock status and clock-fail flag; a set beats a same-cycle clear
  // of the bus writes, only a low-byte write with bit 3 at zero clears the flag, so a high-byte
  // write of the requested source leaves a pending failure visible
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      pll_lock_flag <= 1'b0;
      clock_fail_flag <= 1'b0;
    end else if (i_ce) begin
      pll_lock_flag <= uses_pll(current_source) && i_pll_locked && state != OSD_START;
      if (i_clock_fail && switch_enabled) begin
        clock_fail_flag <= 1'b1;
      end else if (state == OSD_IDLE && switch_request && !switch_locked
                   && requested_source != current_source) begin
        clock_fail_flag <= 1'b0;
      end else if (bus_write && i_avs_address == ADDR_OSC_CONTROL && i_avs_byteenable[0]
                   && !i_avs_writedata[CLK_FAIL_BIT]) begin
        clock_fail_flag <= 1'b0;
      end
    end
  end

  // clock_divisor: written value, then interrupt recovery overrides reduce-enable
  always_comb begin
    next_divisor = clock_divisor;
    if (bus_write && i_avs_address == ADDR_CLOCK_DIVISOR) begin
      next_divisor = merge16(clock_divisor, i_avs_writedata, i_avs_byteenable,
                             CLOCK_DIVISOR_MASK);
    end
    // test the merged value so the interrupt wins over a same-cycle write
    if (i_interrupt && next_divisor[RECOVER_BIT]) begin
      next_divisor[REDUCE_EN_BIT] = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      clock_divisor <= CLOCK_DIVISOR_RST;
    end else if (i_ce) begin
      clock_divisor <= next_divisor;
    end
  end

  // pll feedback and fast rc trim registers
  // no range checks: out-of-range divider codes are left to software
  // the reserved post-divider code is stored and passed on as written
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      pll_feedback_divisor <= PLL_FEEDBACK_RST;
      fast_rc_tuning <= FAST_RC_TUNING_RST;
    end else if (bus_write) begin
      if (i_avs_address == ADDR_PLL_FEEDBACK) begin
        pll_feedback_divisor <= merge16(pll_feedback_divisor, i_avs_writedata,
                                        i_avs_byteenable, PLL_FEEDBACK_MASK);
      end
      if (i_avs_address == ADDR_FAST_RC_TUNING) begin
        fast_rc_tuning <= merge16(fast_rc_tuning, i_avs_writedata, i_avs_byteenable,
                                  FAST_RC_TUNING_MASK);
      end
    end
  end

  // steering outputs; the analog mux switches only on o_mux_select_pulse,
  // issued after the settle count so both clocks are quiet at the edge
  // every output is a flop so the clock logic never sees a decode glitch
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_active_source <= OSD_SRC_FRC_DIVN;
      o_primary_submode <= PRI_EXT_CLOCK;
      o_pll_in_use <= 1'b0;
      o_secondary_osc_enable <= 1'b0;
      o_start_source <= 1'b0;
      o_start_target <= OSD_SRC_FRC_DIVN;
      o_mux_select_pulse <= 1'b0;
      o_pin_remap_lock <= 1'b0;
      o_clock_fail_trap <= 1'b0;
      o_reduce_ratio <= REDUCE_ONE;
      o_fast_rc_postscale <= '0;
      o_pll_post_divider <= '0;
      o_pll_pre_divider <= '0;
      o_pll_multiplier <= '0;
      o_fast_rc_trim <= '0;
    end else if (i_ce) begin
      o_active_source <= current_source;
      o_primary_submode <= i_primary_submode_cfg; // config only
      o_pll_in_use <= uses_pll(current_source);
      o_secondary_osc_enable <= secondary_osc_enable;
      o_start_source <= (state == OSD_START) || (state == OSD_SETTLE);
      o_start_target <= requested_source;
      o_mux_select_pulse <= (state == OSD_DONE);
      o_pin_remap_lock <= pin_remap_lock;
      o_clock_fail_trap <= i_clock_fail && switch_enabled;
      // a clear reduce-enable forces code zero, the 1:1 ratio
      o_reduce_ratio <= clock_divisor[REDUCE_EN_BIT] ? clock_divisor[REDUCE_LSB +: 3]
                                                     : REDUCE_ONE;
      o_fast_rc_postscale <= clock_divisor[FRC_POST_LSB +: 3];
      o_pll_post_divider <= clock_divisor[PLL_POST_LSB +: 2];
      o_pll_pre_divider <= clock_divisor[PLL_PRE_LSB +: 5];
      o_pll_multiplier <= pll_feedback_divisor[8:0];
      o_fast_rc_trim <= fast_rc_tuning[5:0];
    end
  end
endmodule : osd_clock_ctrl

// ---- tb/osd_osc_model.sv ----
// oscillator model: start-up delay, pll lock and new-clock ticks seen by the controller
`timescale 1ns/1ps
module osd_osc_model (
  // controller side
  input wire logic i_core_clk,
  input wire logic i_start,
  input wire logic i_pll_in_use,
  input wire logic i_slow,
  // status back to the controller
  output logic o_osc_ready,
  output logic o_pll_locked,
  output logic o_new_clk_tick
);
  logic [5:0] age;
  // start-up age, cleared between switches so every start pays the full delay
  always_ff @(posedge i_core_clk) begin
    if (!i_start) begin
      age <= 6'h00;
    end else if (age != 6'h3f) begin
      age <= age + 6'h01;
    end
  end
  // slow mode stands for a crystal with a long start-up timer
  assign o_osc_ready = i_start && (age >= (i_slow ? 6'h28 : 6'h03));
  // a running pll source stays locked; during start lock follows start-up
  assign o_pll_locked = i_start ? o_osc_ready : i_pll_in_use;
  // new clock at half the core rate, ticking only during a start once ready
  always_ff @(posedge i_core_clk) begin
    o_new_clk_tick <= o_osc_ready && !o_new_clk_tick;
  end
endmodule : osd_osc_model

// ---- tb/osd_clock_ctrl_props.sv ----
// checker: port properties of the oscillator controller
`timescale 1ns/1ps
module osd_clock_ctrl_props (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // bus
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  // configuration and events
  input wire logic [2:0] i_initial_source_cfg,
  input wire logic [1:0] i_primary_submode_cfg,
  input wire logic [1:0] i_switch_monitor_cfg,
  input wire logic i_clock_fail,
  input wire logic i_new_clk_tick,
  // steering outputs
  input osd_pkg::osd_src_t o_active_source,
  input wire logic [1:0] o_primary_submode,
  input wire logic o_start_source,
  input wire logic o_mux_select_pulse,
  input wire logic o_clock_fail_trap
);
  import osd_pkg::*;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // new-clock ticks seen while a switch runs, saturating at the settle count
  logic [3:0] ticks_seen;
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || !o_start_source) begin
      ticks_seen <= 4'h0;
    end else if (i_new_clk_tick && ticks_seen != SETTLE_CYCLES) begin
      ticks_seen <= ticks_seen + 4'h1;
    end
  end
  a_settle_ticks: assert property (o_mux_select_pulse |-> ticks_seen == SETTLE_CYCLES)
    else $error("switch before ten new-clock ticks");
  // bus answers within the one wait state and only for one cycle
  a_ack_one_wait: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |-> ##[1:2] !o_avs_waitrequest) else $error("bus request not answered");
  a_ack_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("ack longer than one cycle");
  a_upper_zero: assert property (!o_avs_waitrequest |-> o_avs_readdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  // switch completion and settle time
  a_mux_one_pulse: assert property (o_mux_select_pulse |=> !o_mux_select_pulse)
    else $error("mux pulse too long");
  a_settle_gap: assert property ($rose(o_start_source) |-> !o_mux_select_pulse [*8])
    else $error("switch without settle cycles");
  // switching disabled by configuration
  a_locked_out: assert property (i_switch_monitor_cfg[1]
    |-> !o_start_source && !o_mux_select_pulse && !o_clock_fail_trap)
    else $error("switch activity while disabled");
  a_cur_tracks: assert property (i_switch_monitor_cfg[1] && $past(i_rst_n, 2)
    |-> o_active_source == i_initial_source_cfg) else $error("source differs from config");
  a_submode_cfg: assert property ($past(i_rst_n, 2)
    |-> o_primary_submode == i_primary_submode_cfg) else $error("submode differs from config");
  a_trap_follow: assert property (!i_switch_monitor_cfg[1] && $past(i_rst_n, 2)
    |-> o_clock_fail_trap == $past(i_clock_fail)) else $error("trap does not follow failure");
endmodule : osd_clock_ctrl_props

bind osd_clock_ctrl osd_clock_ctrl_props u_props (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .i_initial_source_cfg(i_initial_source_cfg),
  .i_primary_submode_cfg(i_primary_submode_cfg), .i_switch_monitor_cfg(i_switch_monitor_cfg),
  .i_clock_fail(i_clock_fail), .i_new_clk_tick(i_new_clk_tick), .o_active_source(o_active_source),
  .o_primary_submode(o_primary_submode), .o_start_source(o_start_source),
  .o_mux_select_pulse(o_mux_select_pulse), .o_clock_fail_trap(o_clock_fail_trap));

// ---- tb/osd_clock_ctrl_tb.sv ----
// testbench: registers, source switching and fail-over of the oscillator controller
`timescale 1ns/1ps
module osd_clock_ctrl_tb;
  import osd_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] av_addr = 2'h0;
  logic av_rd = 1'b0;
  logic av_wr = 1'b0;
  logic [31:0] av_wd = 32'h0000_0000;
  logic [3:0] av_be = 4'h0;
  logic [2:0] init_cfg = 3'h7;
  logic [1:0] sub_cfg = 2'h1;
  logic [1:0] mon_cfg = 2'h1;
  logic clk_fail = 1'b0;
  logic irq = 1'b0;
  logic slow = 1'b0;
  logic ce = 1'b1;
  logic [31:0] av_rdata, r;
  logic av_wait, osc_ready, pll_locked, new_tick, pll_use, sec_en, start, mux_pulse;
  logic remap_lock, trap;
  osd_src_t active, target;
  logic [1:0] submode, pll_post;
  logic [2:0] reduce, frc_post;
  logic [4:0] pll_pre;
  logic [8:0] pll_mul;
  logic [5:0] trim;
  logic [15:0] wmask [1:3] = '{16'hffdf, 16'h01ff, 16'h003f};
  int err_count = 0;
  int n_compared = 0;

  always #20 core_clk = ~core_clk;

  osd_clock_ctrl dut (.i_core_clk(core_clk), .i_rst_n(rst_n), .i_ce(ce),
    .i_avs_address(av_addr), .i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_writedata(av_wd),
    .i_avs_byteenable(av_be), .o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait),
    .i_initial_source_cfg(init_cfg), .i_primary_submode_cfg(sub_cfg),
    .i_switch_monitor_cfg(mon_cfg), .i_osc_ready(osc_ready), .i_pll_locked(pll_locked),
    .i_new_clk_tick(new_tick), .i_clock_fail(clk_fail), .i_interrupt(irq),
    .o_active_source(active), .o_primary_submode(submode), .o_pll_in_use(pll_use),
    .o_secondary_osc_enable(sec_en), .o_start_source(start), .o_start_target(target),
    .o_mux_select_pulse(mux_pulse), .o_pin_remap_lock(remap_lock), .o_clock_fail_trap(trap),
    .o_reduce_ratio(reduce), .o_fast_rc_postscale(frc_post), .o_pll_post_divider(pll_post),
    .o_pll_pre_divider(pll_pre), .o_pll_multiplier(pll_mul), .o_fast_rc_trim(trim));

  osd_osc_model u_osc (.i_core_clk(core_clk), .i_start(start), .i_pll_in_use(pll_use),
    .i_slow(slow), .o_osc_ready(osc_ready), .o_pll_locked(pll_locked), .o_new_clk_tick(new_tick));

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one bus cycle held until waitrequest is sampled low; read data lands in r
  task bus(input logic rd, input logic [1:0] a, input logic [15:0] d, input logic [3:0] be);
    av_addr <= a;
    av_wd <= {16'h0000, d};
    av_be <= be;
    av_rd <= rd;
    av_wr <= !rd;
    do begin
      @(posedge core_clk);
    end while (av_wait !== 1'b0);
    r = av_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
    @(posedge core_clk);
  endtask : bus

  // request a switch, poll until the request bit drops, then check the result
  task sw(input logic [2:0] c);
    int k;
    slow <= c[0];
    bus(1'b0, 2'h0, {5'h00, c, 8'h01}, 4'h3);
    r = 32'h0000_0001;
    for (k = 0; k < 60 && r[0] !== 1'b0; k++) bus(1'b1, 2'h0, 16'h0000, 4'h3);
    // pll status settles a few cycles after the request bit drops
    bus(1'b1, 2'h0, 16'h0000, 4'h3);
    chk(r, {17'h0, c, 1'b0, c, 2'b00, (c == 3'h1 || c == 3'h3), 5'h00});
    chk({29'h0, active}, {29'h0, c});
    chk({28'h0, pll_use, target}, {28'h0, (c == 3'h1 || c == 3'h3), c});
  endtask : sw

  task pulse_in(input int which);
    if (which == 0) irq <= 1'b1; else clk_fail <= 1'b1;
    @(posedge core_clk);
    irq <= 1'b0;
    clk_fail <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : pulse_in

  task reset_dut;
    rst_n <= 1'b0;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask : reset_dut

  task stop_test;
    if (err_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  // watchdog, far beyond the several hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    stop_test();
  end

  initial begin
    reset_dut();
    // reset values, erased config starts on divided fast rc
    bus(1'b1, 2'h0, 16'h0000, 4'h3);
    chk(r, 32'h0000_7700);
    chk({30'h0, submode}, 32'h1);
    bus(1'b1, 2'h1, 16'h0000, 4'h3);
    chk(r, 32'h0000_3040);
    chk({29'h0, reduce}, 32'h0);
    bus(1'b1, 2'h2, 16'h0000, 4'h3);
    chk(r, 32'h0000_0030);
    bus(1'b1, 2'h3, 16'h0000, 4'h3);
    chk(r, 32'h0000_0000);
    // all ones written: unimplemented bits must read zero
    for (int a = 1; a < 4; a++) begin
      bus(1'b0, a[1:0], 16'hffff, 4'h3);
      bus(1'b1, a[1:0], 16'h0000, 4'h3);
      chk(r, {16'h0000, wmask[a]});
    end
    repeat (2) @(posedge core_clk);
    chk({4'h0, reduce, frc_post, pll_post, pll_pre, pll_mul, trim},
      {4'h0, 3'h7, 3'h7, 2'h3, 5'h1f, 9'h1ff, 6'h3f});
    // low byte lane alone leaves the high byte
    bus(1'b0, 2'h2, 16'h0030, 4'h1);
    bus(1'b1, 2'h2, 16'h0000, 4'h3);
    chk(r, 32'h0000_0130);
    // interrupt drops reduce-enable only while recover is set
    bus(1'b0, 2'h1, 16'h9800, 4'h3);
    repeat (2) @(posedge core_clk);
    chk({29'h0, reduce}, 32'h1);
    pulse_in(0);
    bus(1'b1, 2'h1, 16'h0000, 4'h3);
    chk(r, 32'h0000_9000);
    chk({29'h0, reduce}, 32'h0);
    bus(1'b0, 2'h1, 16'h1800, 4'h3);
    pulse_in(0);
    bus(1'b1, 2'h1, 16'h0000, 4'h3);
    chk(r, 32'h0000_1800);
    // a low clock enable freezes the divisor against an interrupt
    bus(1'b0, 2'h1, 16'h9800, 4'h3);
    ce <= 1'b0;
    pulse_in(0);
    ce <= 1'b1;
    bus(1'b1, 2'h1, 16'h0000, 4'h3);
    chk(r, 32'h0000_9800);
    // pin remap lock and secondary enable
    bus(1'b0, 2'h0, 16'h0742, 4'h3);
    repeat (2) @(posedge core_clk);
    chk({30'h0, remap_lock, sec_en}, 32'h3);
    bus(1'b1, 2'h0, 16'h0000, 4'h3);
    chk(r, 32'h0000_7742);
    // source codes 0 to 6, odd codes with a slow start-up
    for (int c = 0; c < 7; c++) sw(c[2:0]);
    sw(3'h3);
    // failure on a pll source falls back to fast rc with pll
    pulse_in(1);
    bus(1'b1, 2'h0, 16'h0000, 4'h3);
    chk({28'h0, r[14:12], r[3]}, 32'h3);
    bus(1'b0, 2'h0, 16'h0000, 4'h1);
    bus(1'b1, 2'h0, 16'h0000, 4'h3);
    chk({31'h0, r[3]}, 32'h0);
    // request to the running source is dropped
    bus(1'b0, 2'h0, 16'h0101, 4'h3);
    @(posedge core_clk);
    bus(1'b1, 2'h0, 16'h0000, 4'h3);
    chk(r, 32'h0000_1120);
    // lock bit holds the source until cleared
    bus(1'b0, 2'h0, 16'h0180, 4'h3);
    bus(1'b0, 2'h0, 16'h0081, 4'h3);
    repeat (80) @(posedge core_clk);
    bus(1'b1, 2'h0, 16'h0000, 4'h3);
    chk({29'h0, r[14:12]}, 32'h1);
    sw(3'h0);
    // switching disabled: primary start-up, requests and failures ignored
    init_cfg <= 3'h2;
    sub_cfg <= 2'h2;
    mon_cfg <= 2'h2;
    reset_dut();
    bus(1'b0, 2'h0, 16'h0501, 4'h3);
    pulse_in(1);
    bus(1'b1, 2'h0, 16'h0000, 4'h3);
    chk({25'h0, r[14:12], r[3:0]}, 32'h20);
    chk({27'h0, active, submode}, 32'h0a);
    stop_test();
  end
endmodule : osd_clock_ctrl_tb
